//--- ief_core.sv
// interrupt sequencing and opcode fetch cycle with wishbone status slave
//
// Our own choices: the address map and the Wishbone register port.
module ief_core
   import ief_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   // pins from the system
   input  wire logic        i_nmi_n,            // non-maskable request, falling edge
   input  wire logic        i_int_n,            // maskable request, level
   input  wire logic        i_wait_n,           // memory wait request
   input  wire logic        i_bus_request_n,    // bus request from other masters
   input  wire logic [7:0]  i_data,             // data bus in
   // core side, same clock
   input  wire logic        i_instr_last,       // last clock of an instruction
   input  wire logic        i_fetch_start,      // begin a plain opcode fetch
   input  wire logic [15:0] i_pc,               // program counter
   input  wire ief_ctl_t    i_ctl,              // decoded instruction events
   output ief_bus_t         o_bus,              // memory strobes
   output logic [15:0]      o_addr,             // address bus
   output logic [7:0]       o_opcode,           // fetched opcode
   output logic [15:0]      o_vector,           // service address
   output logic [15:0]      o_push_value,       // pc to be stacked
   output ief_evt_t         o_event,            // result pulses
   output logic             o_parity,           // copied secondary flag
   // classic wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [31:0] i_wb_dat,
   input  wire logic [3:0]  i_wb_sel,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack
);
   // synchronised pins
   logic [3:0]  ctl_s;                     // nmi, int, wait, bus_request_n
   logic [7:0]  data_s;                    // data bus after two flops
   logic        nmi_s;
   logic        int_s;
   logic        wait_s;
   logic        bus_request_n_s;
   // interrupt state
   logic        primary_enable_flag_reg;
   logic        secondary_enable_flag_reg;
   ief_mode_t   mode_reg;
   logic        nmi_latch_reg;
   logic        nmi_prev_reg;              // previous synced level for edge
   logic [7:0]  page_reg;
   logic [7:0]  refresh_reg;               // eight bits, all of them stepped by the refresh increment
   // sequencer
   ief_state_t  state_reg;
   ief_state_t  state_next;
   ief_kind_t   kind_reg;
   logic        tbl_hi_reg;                // table read of high byte
   logic [15:0] fetch_pc_reg;
   logic [15:0] ptr_reg;
   logic [7:0]  lo_byte_reg;
   logic [7:0]  cap_reg;                   // byte caught one clock into T3
   // decisions
   logic        boundary;
   logic        take_nmi;
   logic        take_int;
   logic        wb_req;

   ief_sync #(
      .W       (4),
      .RST_VAL (4'hF)
   ) u_sync_ctl (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_d       ({i_nmi_n, i_int_n, i_wait_n, i_bus_request_n}),
      .o_q       (ctl_s)
   );

   ief_sync #(
      .W       (8),
      .RST_VAL (8'hFF)
   ) u_sync_data (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_d       (i_data),
      .o_q       (data_s)
   );

   assign nmi_s    = ctl_s[3];
   assign int_s    = ctl_s[2];
   assign wait_s   = ctl_s[1];
   assign bus_request_n_s = ctl_s[0];

   // boundary decisions, nmi first; enable and disable block their own end
   assign boundary = i_instr_last && (state_reg == IEF_S_IDLE);
   assign take_nmi = boundary && nmi_latch_reg;
   assign take_int = boundary && !nmi_latch_reg && !int_s && primary_enable_flag_reg
                     && bus_request_n_s && !i_ctl.enable_interrupts_instr
                     && !i_ctl.disable_interrupts_instr;
   assign wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;

   // nmi edge latch, a new edge beats the clear of acceptance
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         nmi_prev_reg  <= 1'b1;
         nmi_latch_reg <= 1'b0;
      end else begin
         nmi_prev_reg  <= nmi_s;
         nmi_latch_reg <= (nmi_prev_reg && !nmi_s) || (nmi_latch_reg && !take_nmi);
      end
   end

   // both enable flags
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         primary_enable_flag_reg   <= 1'b0;
         secondary_enable_flag_reg <= 1'b0;
      end else if (take_nmi) begin
         secondary_enable_flag_reg <= primary_enable_flag_reg;
         primary_enable_flag_reg   <= 1'b0;
      end else if (take_int) begin
         primary_enable_flag_reg   <= 1'b0;
         secondary_enable_flag_reg <= 1'b0;
      end else if (i_ctl.enable_interrupts_instr) begin
         primary_enable_flag_reg   <= 1'b1;
         secondary_enable_flag_reg <= 1'b1;
      end else if (i_ctl.disable_interrupts_instr) begin
         primary_enable_flag_reg   <= 1'b0;
         secondary_enable_flag_reg <= 1'b0;
      end else if (i_ctl.nonmaskable_return_instr) begin
         primary_enable_flag_reg   <= secondary_enable_flag_reg;
      end
   end

   // vectoring mode, zero out of reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg <= IEF_MODE_ZERO;
      end else if (i_ctl.select_mode_zero_instr) begin
         mode_reg <= IEF_MODE_ZERO;
      end else if (i_ctl.select_mode_one_instr) begin
         mode_reg <= IEF_MODE_ONE;
      end else if (i_ctl.select_mode_two_instr) begin
         mode_reg <= IEF_MODE_TWO;
      end
   end

   // next clock state; wait holds T2/TW and R2/RW
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         IEF_S_IDLE: begin
            if (take_nmi || take_int || (i_fetch_start && !i_instr_last)) begin
               state_next = IEF_S_T1;
            end
         end
         IEF_S_T1: state_next = IEF_S_T2;
         IEF_S_T2, IEF_S_TW: begin
            state_next = wait_s ? IEF_S_T3 : IEF_S_TW;
         end
         IEF_S_T3: state_next = IEF_S_T4;
         IEF_S_T4: begin
            // mode two goes on to the table reads
            state_next = (kind_reg == IEF_KIND_INT && mode_reg == IEF_MODE_TWO)
                         ? IEF_S_R1 : IEF_S_IDLE;
         end
         IEF_S_R1: state_next = IEF_S_R2;
         IEF_S_R2, IEF_S_RW: begin
            state_next = wait_s ? IEF_S_R3 : IEF_S_RW;
         end
         IEF_S_R3: state_next = tbl_hi_reg ? IEF_S_IDLE : IEF_S_R1;
         default: state_next = IEF_S_IDLE;
      endcase
   end

   // state, cycle kind and captured addresses
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg    <= IEF_S_IDLE;
         kind_reg     <= IEF_KIND_FETCH;
         fetch_pc_reg <= 16'h0000;
         o_push_value <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (state_reg == IEF_S_IDLE && state_next == IEF_S_T1) begin
            fetch_pc_reg <= i_pc;
            kind_reg     <= take_nmi ? IEF_KIND_NMI :
                            (take_int ? IEF_KIND_INT : IEF_KIND_FETCH);
            if (take_nmi || take_int) begin
               o_push_value <= i_pc;
            end
         end
      end
   end

   // byte capture, table pointer and table half
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cap_reg     <= 8'h00;
         ptr_reg     <= 16'h0000;
         lo_byte_reg <= 8'h00;
         tbl_hi_reg  <= 1'b0;
      end else begin
         // data_s trails the pins by two clocks: one clock into T3 it shows
         // the byte that stood on the bus during the read itself
         if (state_reg == IEF_S_T3) begin
            cap_reg <= data_s;
         end
         if (state_reg == IEF_S_T4) begin
            ptr_reg    <= {page_reg, cap_reg & IEF_LSB_CLEAR};
            tbl_hi_reg <= 1'b0;
         end
         if (state_reg == IEF_S_R3 && !tbl_hi_reg) begin
            lo_byte_reg <= data_s;
            tbl_hi_reg  <= 1'b1;
         end
      end
   end

   // address and strobes registered from the next state
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_addr <= 16'h0000;
         o_bus  <= '1;
      end else begin
         unique case (state_next)
            IEF_S_T1, IEF_S_T2, IEF_S_TW: begin
               // acknowledge cycles leave memory strobes idle
               o_addr                        <= (state_reg == IEF_S_IDLE) ? i_pc : fetch_pc_reg;
               o_bus.fetch_cycle_indicator_n <= 1'b0;
               o_bus.memory_request_n        <= (kind_reg == IEF_KIND_INT && state_reg != IEF_S_IDLE)
                                                || (state_reg == IEF_S_IDLE && take_int);
               o_bus.read_n                  <= (kind_reg == IEF_KIND_INT && state_reg != IEF_S_IDLE)
                                                || (state_reg == IEF_S_IDLE && take_int);
               o_bus.refresh_strobe_n        <= 1'b1;
            end
            IEF_S_T3: begin
               o_addr                        <= {page_reg, refresh_reg};
               o_bus.fetch_cycle_indicator_n <= 1'b1;
               o_bus.memory_request_n        <= 1'b0;
               o_bus.read_n                  <= 1'b1;
               o_bus.refresh_strobe_n        <= 1'b0;
            end
            IEF_S_T4: begin
               o_bus.memory_request_n        <= 1'b1;
            end
            IEF_S_R1, IEF_S_R2, IEF_S_RW, IEF_S_R3: begin
               o_addr                        <= (state_reg == IEF_S_T4) ?
                                                {page_reg, cap_reg & IEF_LSB_CLEAR} :
                                                {ptr_reg[15:1],
                                                 tbl_hi_reg || state_reg == IEF_S_R3};
               o_bus.fetch_cycle_indicator_n <= 1'b1;
               o_bus.memory_request_n        <= 1'b0;
               o_bus.read_n                  <= 1'b0;
               o_bus.refresh_strobe_n        <= 1'b1;
            end
            default: begin
               // idle keeps address and refresh strobe until next T1
               o_bus.fetch_cycle_indicator_n <= 1'b1;
               o_bus.memory_request_n        <= 1'b1;
               o_bus.read_n                  <= 1'b1;
            end
         endcase
      end
   end

   // refresh address walks all byte values, one step per fetch
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         refresh_reg <= IEF_REFRESH_RST;
      end else if (state_reg == IEF_S_T4) begin
         refresh_reg <= refresh_reg + IEF_REFRESH_INC;
      end
   end

   // result pulses, opcode and service address
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event  <= '0;
         o_opcode <= 8'h00;
         o_vector <= 16'h0000;
         o_parity <= 1'b0;
      end else begin
         o_event                <= '0;
         o_event.nmi_taken      <= take_nmi;
         o_event.int_taken      <= take_int;
         o_event.service_done   <= i_ctl.maskable_return_instr;
         o_event.parity_valid   <= i_ctl.load_a_page_or_refresh;
         if (i_ctl.load_a_page_or_refresh) begin
            o_parity <= secondary_enable_flag_reg;
         end
         if (state_reg == IEF_S_T4) begin
            unique case (kind_reg)
               IEF_KIND_NMI: begin
                  o_vector             <= IEF_NMI_VEC;
                  o_event.vector_valid <= 1'b1;
               end
               IEF_KIND_INT: begin
                  if (mode_reg == IEF_MODE_ONE) begin
                     o_vector             <= IEF_MODE1_VEC;
                     o_event.vector_valid <= 1'b1;
                  end else if (mode_reg == IEF_MODE_ZERO) begin
                     o_opcode                <= cap_reg;
                     o_event.opcode_valid    <= 1'b1;
                     o_event.from_peripheral <= 1'b1;
                  end
               end
               default: begin
                  o_opcode             <= cap_reg;
                  o_event.opcode_valid <= 1'b1;
               end
            endcase
         end
         if (state_reg == IEF_S_R3 && tbl_hi_reg) begin
            o_vector             <= {data_s, lo_byte_reg};
            o_event.vector_valid <= 1'b1;
         end
      end
   end

   // page register write through byte lane zero
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         page_reg <= IEF_PAGE_RST;
      end else if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == IEF_OFS_PAGE) begin
         page_reg <= i_wb_dat[7:0];
      end
   end

   // wishbone answer one cycle after the strobe, unmapped reads zero
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= 32'h0000_0000;
         if (wb_req && !i_wb_we) begin
            unique case (i_wb_adr)
               IEF_OFS_PAGE:    o_wb_dat[7:0] <= page_reg;
               IEF_OFS_REFRESH: o_wb_dat[7:0] <= refresh_reg;
               IEF_OFS_STATUS: begin
                  o_wb_dat[IEF_ST_PRIMARY]                  <= primary_enable_flag_reg;
                  o_wb_dat[IEF_ST_SECOND]                   <= secondary_enable_flag_reg;
                  o_wb_dat[IEF_ST_MODE_LO+1:IEF_ST_MODE_LO] <= mode_reg;
                  o_wb_dat[IEF_ST_NMI]                      <= nmi_latch_reg;
                  o_wb_dat[IEF_ST_STATE_LO+3:IEF_ST_STATE_LO] <= state_reg;
               end
               default: o_wb_dat <= 32'h0000_0000;
            endcase
         end
      end
   end

   // checks beside the logic
   AST_NMI_EDGE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (nmi_prev_reg && !nmi_s) |=> nmi_latch_reg)
      else $error("nmi edge not latched");
   AST_NMI_FLAGS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      take_nmi |=> !primary_enable_flag_reg
                   && secondary_enable_flag_reg == $past(primary_enable_flag_reg))
      else $error("nmi flag copy wrong");
   AST_INT_FLAGS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      take_int |=> !primary_enable_flag_reg && !secondary_enable_flag_reg
                   && o_event.int_taken && o_push_value == $past(i_pc))
      else $error("maskable acceptance wrong");
   AST_NMI_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (boundary && nmi_latch_reg) |=> o_event.nmi_taken && !o_event.int_taken)
      else $error("nmi did not take precedence");
   AST_EI_DEFER: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (boundary && i_ctl.enable_interrupts_instr) |=> !o_event.int_taken)
      else $error("interrupt taken at enable boundary");
   AST_FETCH_SEQ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == IEF_S_T1) |=> (state_reg == IEF_S_T2)
         ##1 (state_reg == IEF_S_T3 || state_reg == IEF_S_TW))
      else $error("fetch state order wrong");
   AST_WAIT_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ((state_reg == IEF_S_T2 || state_reg == IEF_S_TW) && !wait_s) |=> state_reg == IEF_S_TW)
      else $error("wait not honoured");
   AST_REFRESH: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == IEF_S_T3) |-> !o_bus.refresh_strobe_n && !o_bus.memory_request_n
         && o_bus.read_n && o_addr == {page_reg, refresh_reg})
      else $error("refresh address or strobes wrong");
   AST_MODE1: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == IEF_S_T4 && kind_reg == IEF_KIND_INT && mode_reg == IEF_MODE_ONE)
         |=> o_event.vector_valid && o_vector == IEF_MODE1_VEC)
      else $error("mode one vector wrong");
   AST_TABLE_PTR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == IEF_S_R1) |-> o_addr[0] == tbl_hi_reg && o_addr[15:8] == page_reg)
      else $error("table pointer wrong");
endmodule : ief_core

//--- ief_mem_model.sv
// memory and daisy-chained peripheral facing the fetch unit
module ief_mem_model
   import ief_pkg::*;
#(
   parameter logic [7:0] VEC = 8'h35  // vector byte of the top requester
) (
   input  wire logic        i_ref_clk,
   input  wire ief_bus_t    i_bus,
   input  wire logic [15:0] i_addr,
   input  wire logic        i_slow,
   output logic [7:0]       o_data,
   output logic             o_wait_n
);
   logic [2:0] cnt = 3'h0;  // cycles into the current read
   // undriven bus shows 8'h5A xor the cycle count, a fixed 8'h5A once the count has cleared, never a stale byte
   always_comb begin
      if (!i_bus.fetch_cycle_indicator_n && i_bus.memory_request_n) begin
         o_data = VEC;
      end else if (!i_bus.read_n) begin
         o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'hA5;
      end else begin
         o_data = {5'h00, cnt} ^ 8'h5A;
      end
   end
   // slow memory and peripheral: wait low until three cycles into a read or ack
   always_ff @(posedge i_ref_clk) begin
      cnt <= ((i_bus.read_n && i_bus.fetch_cycle_indicator_n) || cnt == 3'h7) ? 3'h0
             : cnt + 3'h1;
   end
   assign o_wait_n = !(i_slow && cnt < 3'h3);
endmodule : ief_mem_model

//--- ief_pkg.sv
// package: constants, states and carriers of the interrupt and fetch unit
package ief_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0]  IEF_OFS_PAGE    = 8'h00;
   localparam logic [7:0]  IEF_OFS_STATUS  = 8'h04;
   localparam logic [7:0]  IEF_OFS_REFRESH = 8'h08;
   // status field positions
   localparam int          IEF_ST_PRIMARY  = 0;
   localparam int          IEF_ST_SECOND   = 1;
   localparam int          IEF_ST_MODE_LO  = 2;
   localparam int          IEF_ST_NMI      = 4;
   localparam int          IEF_ST_STATE_LO = 8;
   // reset values, fixed vectors, table pointer mask and refresh step
   localparam logic [7:0]  IEF_PAGE_RST    = 8'h00;
   localparam logic [7:0]  IEF_REFRESH_RST = 8'h00;
   localparam logic [15:0] IEF_NMI_VEC     = 16'h0066;
   localparam logic [15:0] IEF_MODE1_VEC   = 16'h0038;
   localparam logic [7:0]  IEF_LSB_CLEAR   = 8'hFE;
   localparam logic [7:0]  IEF_REFRESH_INC = 8'h01;

   // maskable vectoring modes
   typedef enum logic [1:0] {
      IEF_MODE_ZERO = 2'b00,
      IEF_MODE_ONE  = 2'b01,
      IEF_MODE_TWO  = 2'b10
   } ief_mode_t;

   // what the current first machine cycle is for
   typedef enum logic [1:0] {
      IEF_KIND_FETCH = 2'b00,
      IEF_KIND_NMI   = 2'b01,
      IEF_KIND_INT   = 2'b10
   } ief_kind_t;

   // clock states of fetch and table read cycles
   typedef enum logic [3:0] {
      IEF_S_IDLE = 4'b0000,
      IEF_S_T1   = 4'b0001,
      IEF_S_T2   = 4'b0010,
      IEF_S_TW   = 4'b0011,
      IEF_S_T3   = 4'b0100,
      IEF_S_T4   = 4'b0101,
      IEF_S_R1   = 4'b0110,
      IEF_S_R2   = 4'b0111,
      IEF_S_RW   = 4'b1000,
      IEF_S_R3   = 4'b1001
   } ief_state_t;

   // one-cycle instruction events from the core decoder
   typedef struct packed {
      logic enable_interrupts_instr;
      logic disable_interrupts_instr;
      logic select_mode_zero_instr;
      logic select_mode_one_instr;
      logic select_mode_two_instr;
      logic nonmaskable_return_instr;
      logic maskable_return_instr;
      logic load_a_page_or_refresh;
   } ief_ctl_t;

   // active low memory control strobes
   typedef struct packed {
      logic fetch_cycle_indicator_n;
      logic memory_request_n;
      logic read_n;
      logic refresh_strobe_n;
   } ief_bus_t;

   // one-cycle result pulses towards the core
   typedef struct packed {
      logic opcode_valid;
      logic from_peripheral;
      logic vector_valid;
      logic nmi_taken;
      logic int_taken;
      logic service_done;
      logic parity_valid;
   } ief_evt_t;
endpackage : ief_pkg

//--- ief_sync.sv
// two flip-flop synchroniser for pins entering the clock domain
module ief_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_reg;   // first stage, read only by second stage

   // both stages reset to the idle level of the pins
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= RST_VAL;
         o_q      <= RST_VAL;
      end else begin
         meta_reg <= i_d;
         o_q      <= meta_reg;
      end
   end
endmodule : ief_sync

//--- tb_top.sv
// self-checking bench of the interrupt and fetch unit
module tb_top
   import ief_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, nmi_n = 1, int_n = 1, brq_n = 1, last = 0, fs = 0, slow = 0;
   logic cyc = 0, stb = 0, we = 0, par, wack;
   logic [7:0] adr = 0, din, opc;
   logic [31:0] wdat = 0, rdat, wbo;
   logic [15:0] addr, vecv, pushv;
   ief_ctl_t ctl = '0;
   ief_bus_t bus;
   ief_evt_t ev, evs;
   int n_mismatch = 0, total_checks = 0, n;
   logic wt_n;
   ief_core dut (.i_ref_clk(clk), .i_rst(rst), .i_nmi_n(nmi_n), .i_int_n(int_n),
      .i_wait_n(wt_n), .i_bus_request_n(brq_n), .i_data(din), .i_instr_last(last),
      .i_fetch_start(fs), .i_pc(16'h1234), .i_ctl(ctl), .o_bus(bus), .o_addr(addr),
      .o_opcode(opc), .o_vector(vecv), .o_push_value(pushv), .o_event(ev),
      .o_parity(par), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(wbo), .o_wb_ack(wack));
   ief_mem_model mem (.i_ref_clk(clk), .i_bus(bus), .i_addr(addr), .i_slow(slow),
      .o_data(din), .o_wait_n(wt_n));
   initial forever #5 clk = ~clk;
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // classic single wishbone cycle, held until ack is sampled
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      k = 0;
      do begin @(posedge clk); k++; end while (wack !== 1'b1 && k < 20);
      rdat = wbo;
      chk("wishbone ack", 1, wack);
      {cyc, stb} <= 2'b00;
   endtask : wb
   // one-cycle boundary or fetch start with decoded events
   task automatic pulse(logic l, logic f, logic [7:0] c);
      @(posedge clk);
      {last, fs, ctl} <= {l, f, c};
      @(posedge clk);
      {last, fs, ctl} <= '0;
   endtask : pulse
   // cycles from the start edge until a result pulse is seen
   task automatic res();
      n = 0;
      do begin @(posedge clk); n++; end while (!(ev.opcode_valid | ev.vector_valid) && n < 60);
      evs = ev;
      chk("result pulse", 1, ev.opcode_valid | ev.vector_valid);
   endtask : res
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   initial begin #200us; n_mismatch++; complete_run(); end
   initial begin
      repeat (16) @(posedge clk);
      {rst, int_n, brq_n} <= 3'b000;
      wb(0, IEF_OFS_STATUS, 0); chk("status", 0, rdat);
      chk("strobes", 4'hF, bus);
      wb(1, IEF_OFS_PAGE, 32'hFF12); wb(0, IEF_OFS_PAGE, 0); chk("page", 32'h12, rdat);
      wb(0, 8'h40, 0); chk("unmapped", 0, rdat);
      pulse(0, 1, 0); res(); chk("fetch length", 5, n);
      chk("opcode", 8'h34 ^ 8'h12 ^ 8'hA5, opc);
      chk("refresh bus", {16'h1200, 2'b01}, {addr, bus.refresh_strobe_n, bus.memory_request_n});
      wb(0, IEF_OFS_REFRESH, 0); chk("refresh count", 1, rdat);
      slow <= 1; pulse(0, 1, 0); res(); chk("stretched", 1, n > 6); slow <= 0;
      $display("test fetch done");
      pulse(1, 0, 8'h80); pulse(1, 0, 0); brq_n <= 1;
      wb(0, IEF_OFS_STATUS, 0); chk("bus_request_n blocks", 3, rdat);
      pulse(1, 0, 8'h80);
      wb(0, IEF_OFS_STATUS, 0); chk("enable defers", 3, rdat);
      pulse(1, 0, 0); res(); chk("mode zero", {2'b11, 8'h35}, {evs.from_peripheral, evs.opcode_valid, opc});
      chk("push", 16'h1234, pushv); wb(0, IEF_OFS_STATUS, 0); chk("flags cleared", 0, rdat);
      pulse(1, 0, 8'h10); pulse(1, 0, 8'h80); pulse(1, 0, 0); res();
      chk("mode one", 16'h0038, vecv);
      slow <= 1; pulse(1, 0, 8'h08); pulse(1, 0, 8'h80); pulse(1, 0, 0); res(); slow <= 0;
      chk("mode two", {8'h35 ^ 8'hB7, 8'h34 ^ 8'hB7}, vecv);
      $display("test maskable done");
      pulse(1, 0, 8'h80);
      nmi_n <= 0; repeat (4) @(posedge clk); nmi_n <= 1; repeat (4) @(posedge clk);
      pulse(1, 0, 0); res(); chk("nmi vector", 16'h0066, vecv);
      wb(0, IEF_OFS_STATUS, 0); chk("nmi flags", 32'hA, rdat);
      pulse(1, 0, 8'h01); @(posedge clk); chk("parity", 2'b11, {ev.parity_valid, par});
      pulse(1, 0, 8'h02); @(posedge clk); chk("service done", 1, ev.service_done);
      pulse(1, 0, 8'h04); wb(0, IEF_OFS_STATUS, 0); chk("nmi return", 32'hB, rdat);
      $display("test nonmaskable done");
      complete_run();
   end
endmodule : tb_top
